// [logic/twe_line_sync.sv]
// Line synchroniser and bus condition detector
`timescale 1ns/1ns
module twe_line_sync
    import twe_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    // Raw bus lines
    input  wire twe_lines_t  lines_in,
    // Clean lines and conditions
    output twe_lines_t       lines_out,
    output twe_events_t      events_out
);
    twe_lines_t meta_q;
    twe_lines_t sync_q;
    twe_lines_t prev_q;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            meta_q <= TWE_LINE_RESET;
            sync_q <= TWE_LINE_RESET;
            prev_q <= TWE_LINE_RESET;
        end else begin
            meta_q <= lines_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // SDA edges with SCL high are bus conditions only
    assign events_out.start = prev_q.scl && sync_q.scl && prev_q.sda
                              && !sync_q.sda;
    assign events_out.stop  = prev_q.scl && sync_q.scl && !prev_q.sda
                              && sync_q.sda;
    assign events_out.rise  = !prev_q.scl && sync_q.scl;
    assign events_out.fall  = prev_q.scl && !sync_q.scl;
    assign lines_out        = prev_q;
endmodule : twe_line_sync

// [logic/twe_pkg.sv]
// Package for the two-wire serial EEPROM slave
package twe_pkg;
    localparam int          TWE_CLK_HZ       = 25000000;
    localparam int          TWE_WRITE_US     = 4000;
    localparam int          TWE_WRITE_CYCLES =
        TWE_WRITE_US * (TWE_CLK_HZ / 1000000);
    localparam int          TWE_DEPTH        = 16;
    localparam int          TWE_AW           = 4;
    localparam int          TWE_PORT_ADDR    = 6;
    localparam int          TWE_SDA_BIT      = 6;
    localparam int          TWE_SCL_BIT      = 7;
    localparam int          TWE_TYPE_MSB     = 7;
    localparam int          TWE_TYPE_LSB     = 4;
    localparam int          TWE_RW_BIT       = 0;
    localparam logic [2:0]  TWE_BIT_LAST     = 3'h7;
    localparam logic [7:0]  TWE_MEM_RESET    = 8'hFF;
    localparam logic [3:0]  TWE_PTR_RESET    = 4'h0;
    localparam logic [1:0]  TWE_LINE_RESET   = 2'h3;

    typedef enum logic [2:0] {
        TWE_IDLE = 3'b000,
        TWE_CTRL = 3'b001,
        TWE_ADDR = 3'b011,
        TWE_DATA = 3'b010,
        TWE_READ = 3'b110,
        TWE_RACK = 3'b111
    } twe_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } twe_lines_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } twe_events_t;
endpackage : twe_pkg

// [logic/twe_slave.sv]
// Two-wire 16-byte EEPROM slave, top level
`timescale 1ns/1ns
module twe_slave
    import twe_pkg::*;
#(
    parameter int WRITE_CYCLES = TWE_WRITE_CYCLES
)(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    // Serial lines from the port register bits
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // SDA pull-down, enable low while driving
    output logic            sda_out,
    output logic            sda_oe_n_out,
    // Status
    output logic            busy_out
);
    localparam logic [3:0] TYPE_CODE = 4'hA; // Arbitrary type code

    twe_lines_t  lines;
    twe_events_t ev;
    twe_state_t  state_q;
    logic [7:0]  mem_q [TWE_DEPTH];
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic [2:0]  bit_q;
    logic        ninth_q;
    logic        drive_q;
    logic [3:0]  ptr_q;
    logic [7:0]  data_q;
    logic        have_data_q;
    logic        mid_byte_q;
    logic        busy_q;
    logic [31:0] wait_q;
    logic        ack_q;

    twe_line_sync u_sync (
        .clock_in   (clock_in),
        .reset_in   (reset_in),
        .lines_in   ({scl_in, sda_in}),
        .lines_out  (lines),
        .events_out (ev)
    );

    // Byte boundary and decoded control byte
    wire        byte_done  = ev.rise && !ninth_q && bit_q == TWE_BIT_LAST;
    wire [7:0]  byte_in    = {shift_q[6:0], lines.sda};
    wire        type_ok    = byte_in[TWE_TYPE_MSB:TWE_TYPE_LSB]
                             == TYPE_CODE;
    wire        is_read    = byte_in[TWE_RW_BIT];
    wire        ctrl_ack   = type_ok && !busy_q;
    wire        wait_done  = wait_q == WRITE_CYCLES - 1;
    wire        commit     = ev.stop && state_q == TWE_DATA && have_data_q
                             && !mid_byte_q && !busy_q;
    wire [3:0]  ptr_next   = ptr_q + 4'h1;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q     <= TWE_IDLE;
            shift_q     <= 8'h00;
            tx_q        <= 8'h00;
            bit_q       <= 3'h0;
            ninth_q     <= 1'b0;
            ack_q       <= 1'b0;
            ptr_q       <= TWE_PTR_RESET;
            data_q      <= 8'h00;
            have_data_q <= 1'b0;
            mid_byte_q  <= 1'b0;
        end else if (ev.start) begin
            state_q    <= TWE_CTRL;
            bit_q      <= 3'h0;
            ninth_q    <= 1'b0;
            ack_q      <= 1'b0;
            mid_byte_q <= 1'b0;
            have_data_q <= 1'b0;
        end else if (ev.stop) begin
            state_q <= TWE_IDLE;
            ack_q   <= 1'b0;
        end else if (ev.rise && state_q != TWE_IDLE) begin
            if (ninth_q) begin
                ninth_q <= 1'b0;
                if (state_q == TWE_RACK) begin
                    // Master acknowledge asks for the next byte
                    if (!lines.sda) begin
                        state_q <= TWE_READ;
                    end else begin
                        state_q <= TWE_IDLE;
                    end
                end
            end else begin
                shift_q    <= byte_in;
                bit_q      <= bit_q + 3'h1;
                if (byte_done) begin
                    ninth_q <= 1'b1;
                    case (state_q)
                        TWE_CTRL: begin
                            ack_q <= ctrl_ack;
                            if (!ctrl_ack) begin
                                state_q <= TWE_IDLE;
                            end else if (is_read) begin
                                state_q <= TWE_READ;
                            end else begin
                                state_q <= TWE_ADDR;
                            end
                        end
                        TWE_ADDR: begin
                            ack_q   <= 1'b1;
                            ptr_q   <= byte_in[TWE_AW-1:0];
                            state_q <= TWE_DATA;
                        end
                        TWE_DATA: begin
                            ack_q       <= 1'b1;
                            data_q      <= byte_in;
                            have_data_q <= 1'b1;
                        end
                        TWE_READ: begin
                            ack_q   <= 1'b0;
                            ptr_q   <= ptr_next;
                            state_q <= TWE_RACK;
                        end
                        default: begin
                            ack_q <= 1'b0;
                        end
                    endcase
                end
            end
        end else if (ev.fall && state_q == TWE_DATA) begin
            // A bit counts once SCL falls after it, so the clock rise
            // that leads into STOP is not taken as a partial byte
            mid_byte_q <= !ninth_q && bit_q != 3'h0;
        end
        // Load the next byte to send once the ack slot opens
        if (!reset_in && ev.fall && bit_q == 3'h0 && ninth_q
            && (state_q == TWE_READ || state_q == TWE_RACK)) begin
            tx_q <= mem_q[ptr_q];
        end
    end

    // Drive decision on SCL low: ack slot or read data
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            drive_q <= 1'b0;
        end else if (ev.start || ev.stop) begin
            drive_q <= 1'b0;
        end else if (ev.fall) begin
            if (ninth_q && ack_q) begin
                drive_q <= 1'b1;
            end else if (state_q == TWE_READ && ninth_q) begin
                drive_q <= !mem_q[ptr_q][7];
            end else if (state_q == TWE_READ) begin
                drive_q <= !tx_q[~bit_q];
            end else begin
                drive_q <= 1'b0;
            end
        end
    end

    // Storage: write only on a clean, complete byte write
    genvar gi;
    generate
        for (gi = 0; gi < TWE_DEPTH; gi++) begin : g_mem
            always_ff @(posedge clock_in) begin
                if (reset_in) begin
                    mem_q[gi] <= TWE_MEM_RESET;
                end else if (commit && ptr_q == 4'(gi)) begin
                    mem_q[gi] <= data_q;
                end
            end
        end
    endgenerate

    // Self-timed write cycle
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            busy_q <= 1'b0;
            wait_q <= 32'h0;
        end else if (commit) begin
            busy_q <= 1'b1;
            wait_q <= 32'h0;
        end else if (busy_q) begin
            wait_q <= wait_q + 32'h1;
            if (wait_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Open drain: output low, enable low while pulling down
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sda_out      <= 1'b1;
            sda_oe_n_out <= 1'b1;
            busy_out     <= 1'b0;
        end else begin
            sda_out      <= 1'b0;
            sda_oe_n_out <= !drive_q;
            busy_out     <= busy_q;
        end
    end

    // Protocol checks, kept beside the state they watch
    a_busy_no_ack: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_CTRL && busy_q) |=> !ack_q)
        else $error("ack given while busy");

    a_commit_busy: assert property (
        @(posedge clock_in) disable iff (reset_in)
        commit |=> busy_q && mem_q[$past(ptr_q)] == $past(data_q))
        else $error("write not committed");

    a_ptr_hold: assert property (
        @(posedge clock_in) disable iff (reset_in)
        commit |=> ptr_q == $past(ptr_q))
        else $error("pointer moved on write");

    a_abort_mid: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (ev.stop && mid_byte_q) |=> !busy_q || $past(busy_q))
        else $error("partial byte written");

    a_addr_low: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_ADDR) |=> ptr_q == $past(byte_in[3:0]))
        else $error("pointer load wrong");

    a_read_inc: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_READ && !ev.start && !ev.stop)
        |=> ptr_q == $past(ptr_next))
        else $error("read pointer not advanced");

    a_ack_drive: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (ev.fall && ninth_q && ack_q && !ev.start && !ev.stop)
        |=> ##1 !sda_oe_n_out)
        else $error("ack not driven");

    a_busy_len: assert property (
        @(posedge clock_in) disable iff (reset_in)
        $rose(busy_q) |=> busy_q [*8])
        else $error("write cycle too short");

    a_sda_low: assert property (
        @(posedge clock_in) disable iff (reset_in)
        1'b1 |=> !sda_out)
        else $error("sda data not held low");

    a_oe_follow: assert property (
        @(posedge clock_in) disable iff (reset_in)
        1'b1 |=> sda_oe_n_out == !$past(drive_q))
        else $error("sda enable does not follow drive");

    a_busy_follow: assert property (
        @(posedge clock_in) disable iff (reset_in)
        1'b1 |=> busy_out == $past(busy_q))
        else $error("busy output out of step");

    a_start_ctrl: assert property (
        @(posedge clock_in) disable iff (reset_in)
        ev.start |=> state_q == TWE_CTRL && bit_q == 3'h0)
        else $error("start did not open a control byte");

    a_stop_idle: assert property (
        @(posedge clock_in) disable iff (reset_in)
        ev.stop |=> state_q == TWE_IDLE)
        else $error("stop left a transfer open");

    a_wait_bound: assert property (
        @(posedge clock_in) disable iff (reset_in)
        busy_q |-> wait_q < 32'(WRITE_CYCLES))
        else $error("write counter overran");

    a_busy_end: assert property (
        @(posedge clock_in) disable iff (reset_in)
        $fell(busy_q) |-> $past(wait_q) == 32'(WRITE_CYCLES - 1))
        else $error("write cycle ended early");

    a_ctrl_refuse: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_CTRL && !type_ok)
        |=> !ack_q && state_q == TWE_IDLE)
        else $error("foreign control byte accepted");

    a_type_ack: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_CTRL && ctrl_ack)
        |=> ack_q && state_q != TWE_IDLE)
        else $error("own control byte refused");

    a_addr_ack: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_ADDR) |=> ack_q && state_q == TWE_DATA)
        else $error("address byte not taken");

    a_data_buf: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_DATA)
        |=> have_data_q && data_q == $past(byte_in))
        else $error("data buffer not reloaded");

    a_abort_short: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (ev.stop && !have_data_q) |=> !busy_q || $past(busy_q))
        else $error("write started without data");

    a_read_rack: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q == TWE_READ) |=> state_q == TWE_RACK && !ack_q)
        else $error("read byte end not seen");

    a_tx_load: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (ev.fall && ninth_q && bit_q == 3'h0 && (state_q == TWE_READ
        || state_q == TWE_RACK)) |=> tx_q == mem_q[$past(ptr_q)])
        else $error("read byte not loaded");

    a_master_ack: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (ev.rise && ninth_q && state_q == TWE_RACK && !lines.sda)
        |=> state_q == TWE_READ)
        else $error("master ack did not continue read");

    a_bit_wrap: assert property (
        @(posedge clock_in) disable iff (reset_in)
        (byte_done && state_q != TWE_IDLE) |=> bit_q == 3'h0 && ninth_q)
        else $error("ninth clock not armed");
endmodule : twe_slave

// [verification/tb_top.sv]
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ns
module tb_top;
    import twe_pkg::*;
    localparam int         WCYC     = 500;
    // Arbitrary device code, the same value the design chose
    localparam logic [3:0] DEV_CODE = 4'hA;
    localparam logic [7:0] CW       = {DEV_CODE, 3'h2, 1'b0};
    localparam logic [7:0] CR       = {DEV_CODE, 3'h5, 1'b1};
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        scl_m;
    logic        sda_m;
    logic        sda_s;
    logic        sda_oe_n;
    logic        busy;
    wire         sda_w;
    logic        ak;
    logic [7:0]  rd;
    logic [7:0]  img [TWE_DEPTH];
    // Address, data, expected read back
    logic [23:0] rows [4] = '{24'h005A5A, 24'hF3C3C3,
                              24'h0F0101, 24'h17EEEE};
    int          error_cnt = 0;
    int          checks = 0;
    int          n;
    always #20 clock_in = ~clock_in;
    // Pull-up holds the wire high unless a party pulls it low
    assign sda_w = sda_m & (sda_oe_n | sda_s);
    twe_slave #(.WRITE_CYCLES(WCYC)) u_twe_slave (
        .clock_in(clock_in), .reset_in(reset_in), .scl_in(scl_m),
        .sda_in(sda_w), .sda_out(sda_s), .sda_oe_n_out(sda_oe_n),
        .busy_out(busy));
    twe_master_model u_twe_master_model (
        .clock_in(clock_in), .sda_in(sda_w), .scl_out(scl_m),
        .sda_out(sda_m));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic head(input logic [7:0] a);
        u_twe_master_model.start_c();
        u_twe_master_model.put(CW, ak);
        chk(ak, 1'b1);
        u_twe_master_model.put(a, ak);
        chk(ak, 1'b1);
    endtask : head
    task automatic dat(input logic [7:0] d);
        u_twe_master_model.put(d, ak);
        chk(ak, 1'b1);
    endtask : dat
    // First poll lands inside the write time, so it must be refused
    task automatic poll;
        n = 0;
        do begin
            n++;
            u_twe_master_model.start_c();
            u_twe_master_model.put(CW, ak);
        end while (!ak && n < 20);
        u_twe_master_model.stop_c();
        chk(n > 1 && n < 20, 1'b1);
        if (n >= 20) complete_run();
    endtask : poll
    task automatic rdcur(input logic [7:0] e);
        u_twe_master_model.start_c();
        u_twe_master_model.put(CR, ak);
        chk(ak, 1'b1);
        u_twe_master_model.get(1'b0, rd);
        u_twe_master_model.stop_c();
        chk(rd, e);
    endtask : rdcur
    initial begin
        for (int i = 0; i < TWE_DEPTH; i++) img[i] = TWE_MEM_RESET;
        repeat (19) @(posedge clock_in);
        #1;
        chk(sda_oe_n, 1'b1);
        chk(busy, 1'b0);
        @(posedge clock_in);
        #1;
        reset_in = 1'b0;
        repeat (8) @(posedge clock_in);
        #1;
        foreach (rows[i]) begin
            head(rows[i][23:16]);
            dat(rows[i][15:8]);
            u_twe_master_model.stop_c();
            chk(busy, 1'b1);
            poll();
            rdcur(rows[i][7:0]);
            img[rows[i][19:16]] = rows[i][15:8];
        end
        u_twe_master_model.start_c();
        u_twe_master_model.put({~DEV_CODE, 4'h0}, ak);
        u_twe_master_model.stop_c();
        chk(ak, 1'b0);
        head(8'h05);
        u_twe_master_model.stop_c();
        chk(busy, 1'b0);
        head(8'h06);
        dat(8'h11);
        dat(8'h22);
        u_twe_master_model.stop_c();
        img[6] = 8'h22;
        n = 0;
        while (busy && n < 2 * WCYC) begin
            n++;
            @(posedge clock_in);
            #1;
        end
        chk(n > WCYC - 20 && n <= WCYC, 1'b1);
        if (n >= 2 * WCYC) complete_run();
        head(8'h08);
        dat(8'h33);
        dat(8'h44);
        repeat (3) u_twe_master_model.bit_io(1'b0, ak);
        u_twe_master_model.stop_c();
        chk(busy, 1'b0);
        head(8'h00);
        u_twe_master_model.start_c();
        u_twe_master_model.put(CR, ak);
        chk(ak, 1'b1);
        for (int i = 0; i < TWE_DEPTH; i++) begin
            u_twe_master_model.get(i < TWE_DEPTH - 1, rd);
            chk(rd, img[i]);
        end
        u_twe_master_model.stop_c();
        complete_run();
    end
endmodule : tb_top

// [verification/twe_master_model.sv]
// Bit-banging processor model driving the two serial port bits
`timescale 1ns/1ns
module twe_master_model (
    // Clock
    input  wire logic clock_in,
    // Resolved data wire
    input  wire logic sda_in,
    // Port bit drives
    output logic      scl_out,
    output logic      sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    // Data moves mid-low, well clear of both SCL edges
    task automatic bit_io(input logic b, output logic r);
        tick(5);
        sda_out = b;
        tick(5);
        scl_out = 1'b1;
        tick(6);
        r = sda_in;
        tick(4);
        scl_out = 1'b0;
    endtask : bit_io
    task automatic start_c;
        tick(5);
        sda_out = 1'b1;
        tick(5);
        scl_out = 1'b1;
        tick(10);
        sda_out = 1'b0;
        tick(10);
        scl_out = 1'b0;
    endtask : start_c
    task automatic stop_c;
        tick(5);
        sda_out = 1'b0;
        tick(5);
        scl_out = 1'b1;
        tick(10);
        sda_out = 1'b1;
        tick(10);
    endtask : stop_c
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put
    task automatic get(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~more, r);
    endtask : get
endmodule : twe_master_model
